// [rtl/hdtx_pkg.sv]
/*
 * Constants and types shared by the data-link transmit controller and its byte FIFO.
 * Assumes a single 100 MHz ref_clk domain and an APB register port with 8-bit byte addresses.
 */
`default_nettype none

package hdtx_pkg;

   // ------------------------------------------------------------------
   // Register map (byte addresses, one aligned 32-bit word each)
   // ------------------------------------------------------------------
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_LEN = 8'h04;
   localparam logic [7:0] A_DATA = 8'h08;
   localparam logic [7:0] A_CODE = 8'h0C;
   localparam logic [7:0] A_STAT = 8'h10;

   // Control word fields
   localparam int KIND_BIT = 0;
   localparam int FCS_BIT = 1;
   localparam int IDLE_BIT = 2;
   localparam logic [7:0] CTRL_MASK = 8'h07;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [6:0] LEN_RESET = 7'h00;
   localparam logic [5:0] CODE_RESET = 6'h00;

   // Status word fields
   localparam int ST_BUSY = 0;
   localparam int ST_PEND = 1;
   localparam int ST_UNDER = 2;
   localparam int ST_DONE = 3;
   localparam int ST_NEMPTY = 4;
   localparam int ST_NFULL = 5;

   // ------------------------------------------------------------------
   // Line coding constants
   // ------------------------------------------------------------------
   localparam logic [7:0] FLAG = 8'h7E;
   localparam logic [7:0] PAT_ONES = 8'hFF;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [2:0] STUFF_RUN = 3'h5;
   localparam logic [4:0] CNT_OCTET = 5'h08;
   localparam logic [4:0] CNT_WORD = 5'h10;

   // Sizes and link bit rate
   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 4;
   localparam int LINK_DIV = 16;

   typedef enum logic [1:0] {PH_IDLE, PH_DATA, PH_FCS, PH_PAT} hdtx_phase_t;
   typedef enum logic [1:0] {U_FLAG, U_DATA, U_FCS, U_PAT} hdtx_unit_t;

endpackage : hdtx_pkg

`default_nettype wire

// [rtl/hdtx_fifo_if.sv]
/*
 * Valid/ready byte channel between the register port and the serializer, through the FIFO.
 * Assumes one clock; the FIFO owns ready on the fill side and valid/data on the drain side.
 */
`default_nettype none

interface hdtx_fifo_if #(
   parameter int W = 8,
   parameter int D = 4
);
   logic push_valid;
   logic push_ready;
   logic [W-1:0] push_data;
   logic pop_valid;
   logic pop_ready;
   logic [W-1:0] pop_data;

   modport user (output push_valid, push_data, pop_ready, input push_ready, pop_valid, pop_data);
   modport store (input push_valid, push_data, pop_ready, output push_ready, pop_valid, pop_data);
endinterface : hdtx_fifo_if

`default_nettype wire

// [rtl/hdtx_fifo.sv]
/*
 * Small synchronous FIFO with valid/ready on both sides; depth and width are parameters.
 * Assumes the fill side holds push_valid only while it wants to push and honours push_ready.
 */
`default_nettype none

module hdtx_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic ref_clk, // Core clock
   input wire logic rstn, // Asynchronous reset, active low
   hdtx_fifo_if.store q // Fill and drain channel
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;
   localparam logic [AW:0] FULL_C = (AW+1)'(D);
   localparam logic [AW-1:0] LAST_C = AW'(D - 1);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } hdtx_fifo_st_t;

   hdtx_fifo_st_t s_q, s_d;
   logic do_push, do_pop;

   // ------------------------------------------------------------------
   // Flags and next state
   // ------------------------------------------------------------------
   assign q.push_ready = (s_q.cnt != FULL_C);
   assign q.pop_valid = (s_q.cnt != '0);
   assign q.pop_data = s_q.mem[s_q.rp];
   assign do_push = q.push_valid & q.push_ready;
   assign do_pop = q.pop_ready & q.pop_valid;

   // Pointers wrap explicitly so that depths other than powers of two work
   always_comb begin
      s_d = s_q;
      if (do_push) begin
         s_d.mem[s_q.wp] = q.push_data;
         s_d.wp = (s_q.wp == LAST_C) ? '0 : s_q.wp + AW'(1);
      end
      if (do_pop) begin
         s_d.rp = (s_q.rp == LAST_C) ? '0 : s_q.rp + AW'(1);
      end
      if (do_push && !do_pop) begin
         s_d.cnt = s_q.cnt + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
         s_d.cnt = s_q.cnt - (AW+1)'(1);
      end
   end

   // State register
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   a_fifo_bound: assert property (@(posedge ref_clk) disable iff (!rstn)
      (s_q.cnt == FULL_C) && !do_pop |=> !q.push_ready && (s_q.cnt == FULL_C))
      else $error("FIFO left full state without a pop");

endmodule : hdtx_fifo

`default_nettype wire

// [rtl/hdtx_ctrl.sv]
/*
 * Transmit data-link message controller: APB registers, flag fill, framed messages with
 * optional check sequence, repeating bit-pattern messages, and a bit serializer.
 * Assumes the line framer samples dl_bit whenever dl_bit_en pulses, one bit per LINK_DIV cycles.
 */
`default_nettype none

// Behaviour
// - Idle-fill set in framed mode sends only 0x7E flags, overriding messages.
// - Idle-fill clear: flags when nothing pending, otherwise messages go out normally.
// - Idle-fill has no effect in bit-pattern mode.
// - Check-sequence append set adds FCS after each framed message sent in full (not after a starved one); clear omits it.
// - Check-sequence append is ignored in bit-pattern mode.
// - Message kind select: 0 sends bit-pattern message, 1 sends framed message.
module hdtx_ctrl #(
   parameter int LINK_DIV = hdtx_pkg::LINK_DIV,
   parameter int FIFO_DEPTH = hdtx_pkg::FIFO_DEPTH
) (
   input wire logic ref_clk, // Core clock, 100 MHz
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic [7:0] paddr, // APB byte address
   input wire logic psel, // APB select
   input wire logic penable, // APB access phase
   input wire logic pwrite, // APB direction, high for write
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   output logic dl_bit, // Serial data-link bit
   output logic dl_bit_en // One-cycle strobe marking a new dl_bit
);
   localparam logic [7:0] DIV_TOP = 8'(LINK_DIV - 1);

   typedef struct packed {
      logic [7:0] ctrl;
      logic [6:0] len;
      logic [5:0] code;
      logic pend;
      logic underrun;
      logic done;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [7:0] div;
      hdtx_pkg::hdtx_unit_t unit;
      hdtx_pkg::hdtx_phase_t ph;
      logic [15:0] sh;
      logic [4:0] cnt;
      logic [2:0] ones;
      logic [15:0] crc;
      logic [6:0] left;
      logic pat_inf;
      logic bit_o;
      logic bit_en;
   } hdtx_ctrl_st_t;

   hdtx_ctrl_st_t s, n;
   logic tick_w, acc_w, wr_w, load_w, pop_w, mapped_w, fb_w;
   logic [15:0] crc_u;
   logic [31:0] rd_w;

   hdtx_fifo_if #(.W(hdtx_pkg::DATA_W), .D(FIFO_DEPTH)) q_if ();

   hdtx_fifo #(.W(hdtx_pkg::DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .q(q_if)
   );

   // ------------------------------------------------------------------
   // Register read mux and address decode
   // ------------------------------------------------------------------
   always_comb begin
      mapped_w = 1'b1;
      rd_w = '0;
      case (paddr)
         hdtx_pkg::A_CTRL: rd_w[7:0] = s.ctrl;
         hdtx_pkg::A_LEN: rd_w[6:0] = s.len;
         hdtx_pkg::A_DATA: rd_w = '0;
         hdtx_pkg::A_CODE: rd_w[5:0] = s.code;
         hdtx_pkg::A_STAT: begin
            rd_w[hdtx_pkg::ST_BUSY] = (s.ph != hdtx_pkg::PH_IDLE);
            rd_w[hdtx_pkg::ST_PEND] = s.pend;
            rd_w[hdtx_pkg::ST_UNDER] = s.underrun;
            rd_w[hdtx_pkg::ST_DONE] = s.done;
            rd_w[hdtx_pkg::ST_NEMPTY] = q_if.pop_valid;
            rd_w[hdtx_pkg::ST_NFULL] = q_if.push_ready;
         end
         default: mapped_w = 1'b0;
      endcase
   end

   // FIFO fill side: a data write is only completed once there is room
   assign acc_w = psel & penable;
   assign wr_w = acc_w & s.pready & pwrite & ~s.pslverr;
   assign q_if.push_valid = wr_w & (paddr == hdtx_pkg::A_DATA);
   assign q_if.push_data = pwdata[7:0];
   assign q_if.pop_ready = pop_w;

   // ------------------------------------------------------------------
   // Next state: bus slave, bit divider, serializer and message sequencing
   // ------------------------------------------------------------------
   always_comb begin
      n = s;
      load_w = 1'b0;
      pop_w = 1'b0;
      fb_w = 1'b0;
      crc_u = s.crc;
      tick_w = (s.div == 8'h00);
      n.div = tick_w ? DIV_TOP : s.div - 8'h01;
      n.bit_en = 1'b0;

      // One wait state; a data write stalls while the FIFO is full
      n.pready = 1'b0;
      n.pslverr = 1'b0;
      if (acc_w && !s.pready) begin
         if (!(pwrite && paddr == hdtx_pkg::A_DATA && !q_if.push_ready)) begin
            n.pready = 1'b1;
            n.pslverr = ~mapped_w;
            n.prdata = (pwrite || !mapped_w) ? 32'h0000_0000 : rd_w;
         end
      end

      // Sticky flags clear before hardware sets, so a same-cycle event survives
      if (wr_w && paddr == hdtx_pkg::A_STAT) begin
         if (pwdata[hdtx_pkg::ST_UNDER]) n.underrun = 1'b0;
         if (pwdata[hdtx_pkg::ST_DONE]) n.done = 1'b0;
      end

      // Emit one bit per tick; a zero goes in after five ones inside a frame
      if (tick_w) begin
         if (s.cnt == 5'h00) begin
            load_w = 1'b1;
         end else if (s.ones == hdtx_pkg::STUFF_RUN) begin
            n.bit_o = 1'b0;
            n.bit_en = 1'b1;
            n.ones = 3'h0;
         end else begin
            n.bit_o = s.sh[0];
            n.bit_en = 1'b1;
            n.sh = s.sh >> 1;
            n.cnt = s.cnt - 5'h01;
            if ((s.unit == hdtx_pkg::U_DATA || s.unit == hdtx_pkg::U_FCS) && s.sh[0]) begin
               n.ones = s.ones + 3'h1;
            end else begin
               n.ones = 3'h0;
            end
            // Reflected CRC over message bits as sent, before stuffing
            if (s.unit == hdtx_pkg::U_DATA) begin
               fb_w = s.crc[0] ^ s.sh[0];
               crc_u = (s.crc >> 1) ^ (fb_w ? hdtx_pkg::CRC_POLY : 16'h0000);
               n.crc = crc_u;
            end
            load_w = (s.cnt == 5'h01);
         end
      end

      // Choose the next octet or word at each unit boundary; flag is the default
      if (load_w) begin
         n.unit = hdtx_pkg::U_FLAG;
         n.sh = {8'h00, hdtx_pkg::FLAG};
         n.cnt = hdtx_pkg::CNT_OCTET;
         if (!s.ctrl[hdtx_pkg::KIND_BIT]) begin
            // Bit-pattern mode: idle fill and append bits are not looked at
            if (s.pend || (s.ph == hdtx_pkg::PH_PAT && (s.pat_inf || s.left != 7'h00))) begin
               if (s.pend) begin
                  n.pend = 1'b0;
                  n.ph = hdtx_pkg::PH_PAT;
                  n.pat_inf = (s.len == 7'h00);
                  n.left = s.len - 7'h01;
               end else begin
                  n.left = s.left - 7'h01;
               end
               n.unit = hdtx_pkg::U_PAT;
               n.sh = {hdtx_pkg::PAT_ONES, 1'b0, s.code, 1'b0};
               n.cnt = hdtx_pkg::CNT_WORD;
            end else begin
               if (s.ph == hdtx_pkg::PH_PAT) n.done = 1'b1;
               n.ph = hdtx_pkg::PH_IDLE;
            end
         end else if (s.ctrl[hdtx_pkg::IDLE_BIT]) begin
            n.ph = hdtx_pkg::PH_IDLE;
         end else begin
            unique case (s.ph)
               hdtx_pkg::PH_DATA: begin
                  if (s.left != 7'h00) begin
                     if (q_if.pop_valid) begin
                        pop_w = 1'b1;
                        n.unit = hdtx_pkg::U_DATA;
                        n.sh = {8'h00, q_if.pop_data};
                        n.left = s.left - 7'h01;
                     end else begin
                        n.underrun = 1'b1; // Starved mid-frame: close it early
                        n.ph = hdtx_pkg::PH_IDLE;
                     end
                  end else if (s.ctrl[hdtx_pkg::FCS_BIT]) begin
                     n.unit = hdtx_pkg::U_FCS;
                     n.sh = ~crc_u;
                     n.cnt = hdtx_pkg::CNT_WORD;
                     n.ph = hdtx_pkg::PH_FCS;
                  end else begin
                     n.ph = hdtx_pkg::PH_IDLE;
                     n.done = 1'b1;
                  end
               end
               hdtx_pkg::PH_FCS: begin
                  n.ph = hdtx_pkg::PH_IDLE;
                  n.done = 1'b1;
               end
               hdtx_pkg::PH_IDLE, hdtx_pkg::PH_PAT: begin
                  n.ph = hdtx_pkg::PH_IDLE;
                  if (s.pend && s.len != 7'h00) begin
                     n.pend = 1'b0;
                     n.ph = hdtx_pkg::PH_DATA;
                     n.left = s.len;
                     n.crc = hdtx_pkg::CRC_INIT;
                  end
               end
            endcase
         end
      end

      // Configuration writes last, so a send armed now is not lost to a load
      if (wr_w) begin
         case (paddr)
            hdtx_pkg::A_CTRL: begin
               n.ctrl = pwdata[7:0] & hdtx_pkg::CTRL_MASK;
               n.pend = 1'b1;
            end
            hdtx_pkg::A_LEN: n.len = pwdata[6:0];
            hdtx_pkg::A_CODE: n.code = pwdata[5:0];
            default: ;
         endcase
      end
   end

   // State register; every top output is a field of it
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign prdata = s.prdata;
   assign pready = s.pready;
   assign pslverr = s.pslverr;
   assign dl_bit = s.bit_o;
   assign dl_bit_en = s.bit_en;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   a_idle_fill_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && s.ctrl[hdtx_pkg::KIND_BIT] && s.ctrl[hdtx_pkg::IDLE_BIT]
      |=> s.unit == hdtx_pkg::U_FLAG && s.sh[7:0] == 8'h7E && s.ph == hdtx_pkg::PH_IDLE)
      else $error("Idle fill did not load a flag");

   a_frame_start: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && s.ctrl[hdtx_pkg::KIND_BIT] && !s.ctrl[hdtx_pkg::IDLE_BIT] && s.pend
      && s.len != 7'h00 && s.ph == hdtx_pkg::PH_IDLE
      |=> s.ph == hdtx_pkg::PH_DATA && s.left == $past(s.len) && !s.pend)
      else $error("Pending framed message did not start");

   a_no_msg_flags: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && s.ctrl[hdtx_pkg::KIND_BIT] && !s.pend && s.ph == hdtx_pkg::PH_IDLE
      |=> s.unit == hdtx_pkg::U_FLAG ##1 (s.cnt == 5'h08) [*3])
      else $error("Flag fill not sent while nothing pending");

   a_pat_keeps_going: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && !s.ctrl[hdtx_pkg::KIND_BIT] && s.ph == hdtx_pkg::PH_PAT && s.pat_inf
      |=> s.unit == hdtx_pkg::U_PAT && s.cnt == 5'h10)
      else $error("Bit-pattern repeat broken by idle fill");

   a_fcs_append: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && s.ctrl[hdtx_pkg::KIND_BIT] && !s.ctrl[hdtx_pkg::IDLE_BIT] && s.ph == hdtx_pkg::PH_DATA
      && s.left == 7'h00 && s.ctrl[hdtx_pkg::FCS_BIT]
      |=> s.unit == hdtx_pkg::U_FCS && s.cnt == 5'h10 && s.sh == ~$past(crc_u))
      else $error("Check sequence not appended");

   a_fcs_omit: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && s.ctrl[hdtx_pkg::KIND_BIT] && !s.ctrl[hdtx_pkg::IDLE_BIT] && s.ph == hdtx_pkg::PH_DATA
      && s.left == 7'h00 && !s.ctrl[hdtx_pkg::FCS_BIT]
      |=> s.unit == hdtx_pkg::U_FLAG && s.ph == hdtx_pkg::PH_IDLE && s.done)
      else $error("Closing flag missing without check sequence");

   a_pat_no_fcs: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && !s.ctrl[hdtx_pkg::KIND_BIT] |=> s.unit != hdtx_pkg::U_FCS && s.unit != hdtx_pkg::U_DATA)
      else $error("Framed octets loaded in bit-pattern mode");

   a_pat_send: assert property (@(posedge ref_clk) disable iff (!rstn)
      load_w && !s.ctrl[hdtx_pkg::KIND_BIT] && s.pend
      |=> s.ph == hdtx_pkg::PH_PAT && s.sh[15:8] == 8'hFF && s.sh[0] == 1'b0)
      else $error("Bit-pattern send not started");

   a_stuff_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
      tick_w && s.cnt != 5'h00 && s.ones == 3'h5 |=> dl_bit_en && !dl_bit && s.ones == 3'h0)
      else $error("Missing stuffed zero after five ones");

   a_apb_answer: assert property (@(posedge ref_clk) disable iff (!rstn)
      acc_w && !s.pready && !pwrite |=> pready && (pslverr == !$past(mapped_w)))
      else $error("APB read not answered after one wait state");

endmodule : hdtx_ctrl

`default_nettype wire

// [testbench/hdtx_rx_model.sv]
/*
 * Far-end receiver model: finds flags on the serial data link, drops stuffed zeros
 * and keeps the octets of the last frame; also counts one expected 16-bit pattern word.
 * Assumes dl_bit is valid in every cycle in which dl_bit_en is high.
 */
`default_nettype none

module hdtx_rx_model (
   input wire logic ref_clk, // Core clock
   input wire logic rstn, // Reset, active low
   input wire logic dl_bit, // Serial data-link bit
   input wire logic dl_bit_en // Bit strobe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] win = 8'h00;
   logic [15:0] raw = 16'h0000;
   logic [7:0] sh = 8'h00;
   logic [15:0] word_exp = 16'h0000; // Pattern word, set by the bench
   int ones = 0;
   int nb = 0;
   int flags = 0;
   int frames = 0;
   int hits = 0;
   logic [7:0] q[$];
   logic [7:0] last[$];

   // ------------------------------------------------------------------
   // Deframing
   // ------------------------------------------------------------------
   // Sampled on the falling edge so the strobe and bit are settled
   always @(negedge ref_clk) begin
      if (rstn && dl_bit_en) begin
         win = {dl_bit, win[7:1]};
         raw = {dl_bit, raw[15:1]};
         if (raw == word_exp) begin
            hits++;
         end
         if (win == hdtx_pkg::FLAG) begin
            flags++;
            if (q.size() > 0) begin
               last = q;
               frames++;
            end
            q = {};
            nb = 0;
            ones = 0;
         end else if (dl_bit) begin
            ones++;
            // Seven ones in a row cannot be framed data: drop the partial frame
            if (ones >= 7) begin
               q = {};
               nb = 0;
            end else begin
               sh = {1'b1, sh[7:1]};
               nb++;
            end
         end else if (ones == 5) begin
            ones = 0; // Stuffed zero, not data
         end else begin
            ones = 0;
            sh = {1'b0, sh[7:1]};
            nb++;
         end
         if (nb == 8) begin
            q.push_back(sh);
            nb = 0;
         end
      end
   end
endmodule : hdtx_rx_model

`default_nettype wire

// [testbench/tb_hdlc_datalink_tx_control.sv]
/*
 * Self-checking bench for the data-link transmit controller: APB master tasks,
 * one task per scenario, far-end receiver model on the serial output.
 * Assumes the one-wait-state APB slave of the design and a shortened bit period.
 */
`default_nettype none

module tb_hdlc_datalink_tx_control;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LDIV = 4; // Short bit period keeps the run brief
   logic ref_clk;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, dl_bit, dl_bit_en, er;
   int n_fail = 0;
   int n_checks = 0;
   int fr;
   logic [7:0] msg[$];

   hdtx_ctrl #(.LINK_DIV(LDIV), .FIFO_DEPTH(hdtx_pkg::FIFO_DEPTH)) dut (.ref_clk(ref_clk), .rstn(rstn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dl_bit(dl_bit), .dl_bit_en(dl_bit_en));
   hdtx_rx_model m (.ref_clk(ref_clk), .rstn(rstn), .dl_bit(dl_bit), .dl_bit_en(dl_bit_en));

   // ------------------------------------------------------------------
   // Clock, reporting and bus tasks
   // ------------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Request holds until pready is sampled high at a rising edge; the answer is taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 500) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 500) n_fail++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask : rdchk

   // Reflected CRC over the queued octets, complemented for the wire
   function automatic logic [15:0] fcs(input logic [7:0] b[$]);
      logic [15:0] c;
      c = hdtx_pkg::CRC_INIT;
      foreach (b[i]) begin
         c = c ^ {8'h00, b[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ hdtx_pkg::CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction : fcs

   task automatic load();
      fr = m.frames;
      apb(1'b1, hdtx_pkg::A_LEN, 32'(msg.size()));
      foreach (msg[i]) apb(1'b1, hdtx_pkg::A_DATA, {24'h0, msg[i]});
   endtask : load

   task automatic wait_done();
      int k;
      k = 0;
      rd = 32'h0;
      while (rd[hdtx_pkg::ST_DONE] !== 1'b1 && k < 300) begin
         apb(1'b0, hdtx_pkg::A_STAT, 32'h0);
         k++;
      end
      chk({31'h0, rd[hdtx_pkg::ST_DONE]}, 32'h1);
      apb(1'b1, hdtx_pkg::A_STAT, 32'h0000000C);
   endtask : wait_done

   task automatic expect_frame(input logic fcs_on);
      logic [15:0] c;
      int k;
      c = fcs(msg);
      k = 0;
      if (fcs_on) begin
         msg.push_back(c[7:0]);
         msg.push_back(c[15:8]);
      end
      while (m.frames < fr + 1 && k < 5000) begin
         @(posedge ref_clk);
         k++;
      end
      chk(32'(m.frames), 32'(fr + 1));
      chk(32'(m.last.size()), 32'(msg.size()));
      foreach (msg[i]) chk({24'h0, m.last[i]}, {24'h0, msg[i]});
      wait_done();
   endtask : expect_frame

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_regs();
      rdchk(hdtx_pkg::A_CTRL, 32'h00000000);
      rdchk(hdtx_pkg::A_LEN, 32'h00000000);
      rdchk(hdtx_pkg::A_CODE, 32'h00000000);
      rdchk(hdtx_pkg::A_STAT, 32'h00000020);
      rdchk(hdtx_pkg::A_DATA, 32'h00000000);
      rdchk(8'h14, 32'h00000000);
      chk({31'h0, er}, 32'h1);
      apb(1'b1, hdtx_pkg::A_CODE, 32'hFFFFFFFF);
      rdchk(hdtx_pkg::A_CODE, 32'h0000003F);
      apb(1'b1, hdtx_pkg::A_LEN, 32'hFFFFFFFF);
      rdchk(hdtx_pkg::A_LEN, 32'h0000007F);
      chk({31'h0, er}, 32'h0);
   endtask : t_regs

   task automatic t_idle_flags();
      int f0;
      f0 = m.flags;
      repeat (40 * LDIV) @(posedge ref_clk);
      chk({31'h0, m.flags >= f0 + 4}, 32'h1);
      chk(32'(m.frames), 32'h0);
   endtask : t_idle_flags

   task automatic t_framed_fcs();
      msg = '{8'h02, 8'h01, 8'h3C, 8'hFF};
      load();
      rdchk(hdtx_pkg::A_STAT, 32'h00000010);
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000003);
      expect_frame(1'b1);
   endtask : t_framed_fcs

   task automatic t_framed_plain();
      msg = '{8'h7E, 8'hF8, 8'h00};
      load();
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000001);
      expect_frame(1'b0);
   endtask : t_framed_plain

   task automatic t_idle_fill();
      msg = '{8'h55, 8'hAA};
      load();
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000005);
      repeat (60 * LDIV) @(posedge ref_clk);
      chk(32'(m.frames), 32'(fr));
      apb(1'b0, hdtx_pkg::A_STAT, 32'h0);
      chk({31'h0, rd[hdtx_pkg::ST_NEMPTY]}, 32'h1);
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000001);
      expect_frame(1'b0);
   endtask : t_idle_fill

   task automatic t_bit_pattern();
      int h0;
      int k;
      h0 = m.hits;
      k = 0;
      fr = m.frames;
      m.word_exp = {8'hFF, 1'b0, 6'h2D, 1'b0};
      apb(1'b1, hdtx_pkg::A_CODE, 32'h0000002D);
      apb(1'b1, hdtx_pkg::A_LEN, 32'h00000002);
      // Append and idle fill set too: both must be ignored here
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000006);
      wait_done();
      while (m.hits < h0 + 2 && k < 2000) begin
         @(posedge ref_clk);
         k++;
      end
      chk(32'(m.hits - h0), 32'h2);
      chk(32'(m.frames), 32'(fr));
      // Zero count repeats until framed mode is chosen; idle fill set must not stop it
      h0 = m.hits;
      k = 0;
      apb(1'b1, hdtx_pkg::A_LEN, 32'h00000000);
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000004);
      while (m.hits < h0 + 4 && k < 2000) begin
         @(posedge ref_clk);
         k++;
      end
      apb(1'b0, hdtx_pkg::A_STAT, 32'h0);
      chk(rd & 32'h00000009, 32'h00000001);
      msg = '{8'hA5};
      load();
      apb(1'b1, hdtx_pkg::A_CTRL, 32'h00000001);
      expect_frame(1'b0);
   endtask : t_bit_pattern

   // ------------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      t_regs();
      t_idle_flags();
      t_framed_fcs();
      t_framed_plain();
      t_idle_fill();
      t_bit_pattern();
      summarize();
   end

   // Whole run needs well under a third of this span
   initial begin
      repeat (60000) @(posedge ref_clk);
      n_fail++;
      summarize();
   end
endmodule : tb_hdlc_datalink_tx_control

`default_nettype wire
